// ==== rtl/reset_timeout_sequencer_params.svh ====
// Operation
// - six reset causes kept apart: power-on, pin run/sleep, watchdog reset/wake, droop
// - reset-exempt registers cleared to 0 after power-on, kept on every other cause
// - ordinary registers reset on all causes except wake-up from sleep (watchdog or irq)
// - core waits about 5-10 us after power-on, droop or wake, in parallel
// - external reset pin passes a glitch filter, short pulses ignored
// - watchdog reset stays internal, never drives the reset pin
// - configuration bit makes the shared pin reset input or general I/O
// - power-up delay of 72 ms on internal RC clock holds reset
// - power-up delay runs only when its enable bit is 0
// - oscillator settle counts 1024 clock pin cycles after power-up delay
// - settle timer only in crystal modes, only after power-on, droop or wake
// - droop longer than about 100 us resets when droop detection enabled
// - droop reset held until supply recovers, then power-up delay; droop restarts
// - power-up delay enable independent of droop reset enable
// - power-up: delay, then 1024 oscillator cycles, then release
// - pin held low past all delays: execution starts when pin rises
// - cause register bit 0 droop flag, cleared by droop reset, set by software
// - cause register bit 1 cleared by power-on only, set by software
// - timeout and power-down flags differ per cause
// - flags: power-on 11, watchdog reset 01, watchdog wake 00, sleep pin/irq 10
// - reset loads address 000h; wake continues or jumps to 0004h with irq enable
`ifndef RESET_TIMEOUT_SEQUENCER_PARAMS_SVH
`define RESET_TIMEOUT_SEQUENCER_PARAMS_SVH
// ==========================================================
// clock and times
`define CLK_MHZ 200
`define POWERUP_TIME_MS 72
`define DROOP_TIME_US 100
`define CPU_START_US 5
`define PIN_FILTER_NS 50
`define START_CYCLES (`CPU_START_US * `CLK_MHZ)
`define FILTER_CYCLES (`PIN_FILTER_NS * `CLK_MHZ / 1000)
`define SETTLE_EDGES 1024
// ==========================================================
// register map
`define ADDR_CAUSE 12'h000
`define ADDR_SCRATCH 12'h004
`define ADDR_STATE 12'h008
`define BIT_DROOP 0
`define BIT_POR 1
`define BIT_TIMEOUT 2
`define BIT_POWERDOWN 3
// ==========================================================
// vectors and modes
`define PC_RESET_VEC 13'h0000
`define PC_IRQ_VEC 13'h0004
`define MODE_LOW_POWER 3'h0
`define MODE_STANDARD 3'h1
`define MODE_HIGH_SPEED 3'h2
`endif

// ==== rtl/reset_timeout_sequencer_pkg.sv ====
package reset_timeout_sequencer_pkg;
  typedef enum logic [2:0] {SEQ_POR, SEQ_DROOP, SEQ_DELAY, SEQ_SETTLE, SEQ_WAIT, SEQ_RUN} seq_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic powerup_delay_enable_n;
    logic supply_droop_enable;
    logic external_reset_pin_enable;
    logic [2:0] osc_mode;
  } cfg_t;

  typedef struct packed {
    logic droop;
    logic watchdog_timeout;
    logic wake_irq;
    logic sleeping;
    logic global_irq_enable;
  } cause_t;

  typedef struct packed {
    logic core_run;
    logic ordinary_reset;
    logic pc_load;
    logic pc_continue;
    logic [12:0] pc_target;
    logic timeout_flag;
    logic powerdown_flag;
    logic shared_io_pin;
  } core_t;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic droop_s1;
    logic droop_s2;
    logic dog_s1;
    logic dog_s2;
    logic dog_s3;
    logic wake_s1;
    logic wake_s2;
    logic wake_s3;
    logic osc_prev;
    logic pin_filt;
    logic [3:0] filt_cnt;
    logic [23:0] droop_cnt;
    seq_t seq;
    logic [23:0] delay_cnt;
    logic [10:0] settle_cnt;
    logic [9:0] start_cnt;
    logic droop_bit;
    logic por_bit;
    logic [7:0] scratch;
    core_t core;
    apb_rsp_t rsp;
  } state_t;
endpackage

// ==== rtl/reset_timeout_sequencer.sv ====
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "reset_timeout_sequencer_params.svh"
module reset_timeout_sequencer
  import reset_timeout_sequencer_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = `POWERUP_TIME_MS * 1000 * `CLK_MHZ,
  parameter int unsigned DROOP_CYCLES = `DROOP_TIME_US * `CLK_MHZ
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire apb_req_t apb_req_in,
  output apb_rsp_t apb_rsp_out,
  input wire cfg_t cfg_in,
  input wire cause_t cause_in,
  input wire logic external_reset_pin_in,
  input wire logic clock_input_pin_in,
  output core_t core_out
);
  state_t q;
  state_t d;
  logic osc_edge;
  logic pin_low;
  logic droop_trip;
  logic dog_ev;
  logic wake_ev;
  logic [7:0] cause_byte;

  // ==========================================================
  // helpers
  function automatic logic is_crystal(input logic [2:0] mode);
    return mode == `MODE_LOW_POWER || mode == `MODE_STANDARD || mode == `MODE_HIGH_SPEED;
  endfunction

  function automatic logic reg_hit(input logic [11:0] addr);
    return addr == `ADDR_CAUSE || addr == `ADDR_SCRATCH || addr == `ADDR_STATE;
  endfunction

  // first state of a power-on or droop sequence
  function automatic seq_t power_seq(input cfg_t cfg);
    if (!cfg.powerup_delay_enable_n) begin
      return SEQ_DELAY;
    end else if (is_crystal(cfg.osc_mode)) begin
      return SEQ_SETTLE;
    end
    return SEQ_WAIT;
  endfunction

  assign apb_rsp_out = q.rsp;
  assign core_out = q.core;

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    d.pin_s1 = external_reset_pin_in;
    d.pin_s2 = q.pin_s1;
    d.droop_s1 = cause_in.droop;
    d.droop_s2 = q.droop_s1;
    d.dog_s1 = cause_in.watchdog_timeout;
    d.dog_s2 = q.dog_s1;
    d.dog_s3 = q.dog_s2;
    d.wake_s1 = cause_in.wake_irq;
    d.wake_s2 = q.wake_s1;
    d.wake_s3 = q.wake_s2;
    d.osc_prev = clock_input_pin_in;
    osc_edge = clock_input_pin_in & ~q.osc_prev;
    dog_ev = q.dog_s2 & ~q.dog_s3;
    wake_ev = q.wake_s2 & ~q.wake_s3;

    if (q.pin_s2 == q.pin_filt) begin
      d.filt_cnt = 4'h0;
    end else if (q.filt_cnt == 4'(`FILTER_CYCLES - 1)) begin
      d.pin_filt = q.pin_s2;
      d.filt_cnt = 4'h0;
    end else begin
      d.filt_cnt = q.filt_cnt + 4'h1;
    end
    pin_low = cfg_in.external_reset_pin_enable & ~q.pin_filt;
    d.core.shared_io_pin = cfg_in.external_reset_pin_enable ? 1'b0 : q.pin_filt;

    droop_trip = 1'b0;
    if (cfg_in.supply_droop_enable && q.droop_s2) begin
      if (q.droop_cnt == 24'(DROOP_CYCLES - 1)) begin
        droop_trip = 1'b1;
      end else begin
        d.droop_cnt = q.droop_cnt + 24'h1;
      end
    end else begin
      d.droop_cnt = 24'h0;
    end

    // ==========================================================
    // register bus: answer one cycle after setup
    cause_byte = {4'h0, q.core.powerdown_flag, q.core.timeout_flag, q.por_bit, q.droop_bit};
    d.rsp.pready = 1'b0;
    d.rsp.pslverr = 1'b0;
    if (apb_req_in.psel && !apb_req_in.penable) begin
      d.rsp.pready = 1'b1;
      d.rsp.pslverr = !reg_hit(apb_req_in.paddr);
      d.rsp.prdata = 32'h0;
      if (!apb_req_in.pwrite) begin
        unique case (apb_req_in.paddr)
          `ADDR_CAUSE: d.rsp.prdata = {24'h0, cause_byte};
          `ADDR_SCRATCH: d.rsp.prdata = {24'h0, q.scratch};
          `ADDR_STATE: d.rsp.prdata = {27'h0, q.pin_filt, 1'b0, q.seq};
          default: d.rsp.prdata = 32'h0;
        endcase
      end
    end
    if (apb_req_in.psel && apb_req_in.penable && q.rsp.pready && apb_req_in.pwrite && !q.rsp.pslverr
        && apb_req_in.pstrb[0]) begin
      if (apb_req_in.paddr == `ADDR_CAUSE) begin
        d.droop_bit = apb_req_in.pwdata[`BIT_DROOP];
        d.por_bit = apb_req_in.pwdata[`BIT_POR];
      end
      // scratch kept on all later resets except power-on, which clears it
      if (apb_req_in.paddr == `ADDR_SCRATCH) begin
        d.scratch = apb_req_in.pwdata[7:0];
      end
    end

    // ==========================================================
    // sequencer; hardware updates placed after bus writes so they win
    d.core.pc_load = 1'b0;
    // start delay runs beside other timers
    if (q.start_cnt != 10'h0) begin
      d.start_cnt = q.start_cnt - 10'h1;
    end
    unique case (q.seq)
      SEQ_POR: begin
        d.core.timeout_flag = 1'b1;
        d.core.powerdown_flag = 1'b1;
        d.por_bit = 1'b0;
        d.start_cnt = 10'(`START_CYCLES - 1);
        d.delay_cnt = 24'(POWERUP_CYCLES - 1);
        d.settle_cnt = 11'(`SETTLE_EDGES - 1);
        d.core.pc_continue = 1'b0;
        d.core.pc_target = `PC_RESET_VEC;
        d.seq = power_seq(cfg_in);
      end
      SEQ_DROOP: begin
        if (!q.droop_s2) begin
          d.start_cnt = 10'(`START_CYCLES - 1);
          d.delay_cnt = 24'(POWERUP_CYCLES - 1);
          d.settle_cnt = 11'(`SETTLE_EDGES - 1);
          // delay enable read on its own
          d.seq = power_seq(cfg_in);
        end
      end
      SEQ_DELAY: begin
        if (q.delay_cnt == 24'h0) begin
          d.seq = is_crystal(cfg_in.osc_mode) ? SEQ_SETTLE : SEQ_WAIT;
        end else begin
          d.delay_cnt = q.delay_cnt - 24'h1;
        end
      end
      SEQ_SETTLE: begin
        if (osc_edge) begin
          if (q.settle_cnt == 11'h0) begin
            d.seq = SEQ_WAIT;
          end else begin
            d.settle_cnt = q.settle_cnt - 11'h1;
          end
        end
      end
      SEQ_WAIT: begin
        if (q.start_cnt == 10'h0 && !pin_low) begin
          d.seq = SEQ_RUN;
          d.core.pc_load = 1'b1;
          d.core.ordinary_reset = 1'b0;
        end
      end
      default: begin
        // cause priority: droop, pin, watchdog, wake
        if (droop_trip) begin
          d.seq = SEQ_DROOP;
          d.droop_bit = 1'b0;
          d.core.timeout_flag = 1'b1;
          d.core.powerdown_flag = 1'b1;
          d.core.ordinary_reset = 1'b1;
          d.core.pc_continue = 1'b0;
          d.core.pc_target = `PC_RESET_VEC;
        end else if (pin_low) begin
          if (cause_in.sleeping) begin
            d.core.timeout_flag = 1'b1;
            d.core.powerdown_flag = 1'b0;
          end
          d.core.ordinary_reset = 1'b1;
          d.core.pc_continue = 1'b0;
          d.core.pc_target = `PC_RESET_VEC;
          d.seq = SEQ_WAIT;
        end else if (dog_ev && cause_in.sleeping) begin
          d.core.timeout_flag = 1'b0;
          d.core.powerdown_flag = 1'b0;
          d.core.pc_continue = 1'b1;
          d.start_cnt = 10'(`START_CYCLES - 1);
          d.settle_cnt = 11'(`SETTLE_EDGES - 1);
          // settle only on wake in crystal mode
          d.seq = is_crystal(cfg_in.osc_mode) ? SEQ_SETTLE : SEQ_WAIT;
        end else if (dog_ev) begin
          d.core.timeout_flag = 1'b0;
          d.core.powerdown_flag = 1'b1;
          d.core.ordinary_reset = 1'b1;
          d.core.pc_continue = 1'b0;
          d.core.pc_target = `PC_RESET_VEC;
          d.seq = SEQ_WAIT;
        end else if (wake_ev && cause_in.sleeping) begin
          d.core.timeout_flag = 1'b1;
          d.core.powerdown_flag = 1'b0;
          d.core.pc_continue = ~cause_in.global_irq_enable;
          d.core.pc_target = cause_in.global_irq_enable ? `PC_IRQ_VEC : `PC_RESET_VEC;
          d.start_cnt = 10'(`START_CYCLES - 1);
          d.settle_cnt = 11'(`SETTLE_EDGES - 1);
          d.seq = is_crystal(cfg_in.osc_mode) ? SEQ_SETTLE : SEQ_WAIT;
        end
      end
    endcase
    if ((q.seq == SEQ_DELAY || q.seq == SEQ_SETTLE || q.seq == SEQ_WAIT)
        && cfg_in.supply_droop_enable && q.droop_s2) begin
      d.seq = SEQ_DROOP;
      d.droop_bit = 1'b0;
      d.core.timeout_flag = 1'b1;
      d.core.powerdown_flag = 1'b1;
      d.core.ordinary_reset = 1'b1;
      d.core.pc_continue = 1'b0;
      d.core.pc_target = `PC_RESET_VEC;
      d.core.pc_load = 1'b0;
    end
    // core held while any delay runs
    d.core.core_run = d.seq == SEQ_RUN;
  end

  // ==========================================================
  // state register; power-on is the asynchronous reset
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
      q.pin_s1 <= 1'b1;
      q.pin_s2 <= 1'b1;
      q.pin_filt <= 1'b1;
      q.seq <= SEQ_POR;
      q.core.ordinary_reset <= 1'b1;
      q.core.timeout_flag <= 1'b1;
      q.core.powerdown_flag <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== verification/reset_timeout_sequencer_props.sv ====
`timescale 1ns/1ps
module rts_props
  import reset_timeout_sequencer_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = 200,
  parameter int unsigned DROOP_CYCLES = 50
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire apb_req_t apb_req_in,
  input wire apb_rsp_t apb_rsp_out,
  input wire cfg_t cfg_in,
  input wire cause_t cause_in,
  input wire logic external_reset_pin_in,
  input wire logic clock_input_pin_in,
  input wire core_t core_out
);
  // ==========================================
  // helper counters
  // up_q only grows, so the bound stays safe on later resets
  logic [31:0] up_q;
  logic [31:0] droop_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      up_q <= '0;
      droop_q <= '0;
    end else begin
      up_q <= core_out.core_run ? up_q : up_q + 32'h1;
      droop_q <= cause_in.droop ? droop_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================
  // properties
  sequence s_setup;
    apb_req_in.psel && !apb_req_in.penable;
  endsequence
  sequence s_access;
    apb_req_in.psel && apb_req_in.penable && apb_rsp_out.pready;
  endsequence
  sequence s_pin_low;
    (!external_reset_pin_in)[*8] ##1 (!external_reset_pin_in)[*8];
  endsequence
  property p_apb_ready;
    s_setup |=> s_access;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("no ready one cycle after setup");
  property p_load_on_run;
    $rose(core_out.core_run) |-> core_out.pc_load;
  endproperty
  a_load_on_run: assert property (p_load_on_run)
    else $error("core released without address load");
  property p_reset_vector;
    core_out.pc_load && $past(core_out.ordinary_reset) |-> core_out.pc_target == 13'h000 && !core_out.pc_continue;
  endproperty
  a_reset_vector: assert property (p_reset_vector)
    else $error("reset release not at address zero");
  property p_run_excl;
    core_out.ordinary_reset |-> !core_out.core_run;
  endproperty
  a_run_excl: assert property (p_run_excl)
    else $error("core runs while registers held in reset");
  property p_powerup_delay_timer;
    $rose(core_out.core_run) && !cfg_in.powerup_delay_enable_n |-> up_q >= POWERUP_CYCLES;
  endproperty
  a_powerup_delay_timer: assert property (p_powerup_delay_timer)
    else $error("release before power-up delay ended");
  property p_droop;
    cfg_in.supply_droop_enable && droop_q > DROOP_CYCLES + 8 |-> !core_out.core_run;
  endproperty
  a_droop: assert property (p_droop)
    else $error("long droop did not hold reset");
  property p_pin_hold;
    cfg_in.external_reset_pin_enable throughout s_pin_low |-> !core_out.core_run;
  endproperty
  a_pin_hold: assert property (p_pin_hold)
    else $error("core runs with reset pin held low");
  property p_por_flags;
    $rose(rstn_in) |-> core_out.timeout_flag && core_out.powerdown_flag;
  endproperty
  a_por_flags: assert property (p_por_flags)
    else $error("flags not set after power-on");
  property p_pin_mode;
    cfg_in.external_reset_pin_enable && $past(cfg_in.external_reset_pin_enable) |-> !core_out.shared_io_pin;
  endproperty
  a_pin_mode: assert property (p_pin_mode)
    else $error("shared pin shows data in reset mode");
endmodule

bind reset_timeout_sequencer rts_props #(
  .POWERUP_CYCLES(POWERUP_CYCLES),
  .DROOP_CYCLES(DROOP_CYCLES)
) u_props (
  .clock_in(clock_in),
  .rstn_in(rstn_in),
  .apb_req_in(apb_req_in),
  .apb_rsp_out(apb_rsp_out),
  .cfg_in(cfg_in),
  .cause_in(cause_in),
  .external_reset_pin_in(external_reset_pin_in),
  .clock_input_pin_in(clock_input_pin_in),
  .core_out(core_out)
);

// ==== verification/pin_supply_model.sv ====
`timescale 1ns/1ps
module pin_supply_model (
  input wire logic clock_in,
  input wire logic pin_low_in,
  input wire logic droop_in,
  output logic pin_out,
  output logic droop_out,
  output logic osc_out
);
  // ==========================================
  // reset pin, pull-up when released
  // pin held low by far side
  assign pin_out = pin_low_in ? 1'b0 : 1'b1;
  assign droop_out = droop_in;
  // ==========================================
  // crystal runs free at half the core rate
  initial osc_out = 1'b0;
  always @(posedge clock_in) begin
    osc_out <= ~osc_out;
  end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`include "reset_timeout_sequencer_params.svh"
module tb
  import reset_timeout_sequencer_pkg::*;
;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  cfg_t cfg = {1'b0, 1'b1, 1'b1, 3'h1};
  cause_t cause = '0;
  core_t core;
  logic pin_low = 1'b0;
  logic droop = 1'b0;
  logic pin;
  logic droop_w;
  logic osc;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  always #2.5 clock_in = ~clock_in;
  pin_supply_model u_model (.clock_in(clock_in), .pin_low_in(pin_low), .droop_in(droop),
    .pin_out(pin), .droop_out(droop_w), .osc_out(osc));
  reset_timeout_sequencer #(.POWERUP_CYCLES(200), .DROOP_CYCLES(50)) u_dut (.clock_in(clock_in),
    .rstn_in(rstn_in), .apb_req_in(req), .apb_rsp_out(rsp), .cfg_in(cfg), .cause_in({droop_w, cause[3:0]}),
    .external_reset_pin_in(pin), .clock_input_pin_in(osc), .core_out(core));
  // ==========================================
  // bench tasks
  task automatic end_of_test();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    error_cnt++;
    end_of_test();
  endtask
  // 33 bits so the error flag of a read is compared too
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until ready is sampled, then one idle edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [32:0] r);
    int k;
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    req.pstrb <= 4'hf;
    @(posedge clock_in);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    if (rsp.pready !== 1'b1) hang();
    r = {rsp.pslverr, rsp.prdata};
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask
  task automatic wait_load(output int c);
    c = 0;
    do begin
      @(posedge clock_in);
      c++;
    end while (core.pc_load !== 1'b1 && c < 6000);
    if (core.pc_load !== 1'b1) hang();
  endtask
  task automatic kick(input int b);
    cause[b] <= 1'b1;
    repeat (4) @(posedge clock_in);
    cause[b] <= 1'b0;
    wait_load(n);
  endtask
  // ==========================================
  // scenarios
  initial begin
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    wait_load(n);
    check(core.pc_target, 32'h0);
    check({core.timeout_flag, core.powerdown_flag}, 32'h3);
    rdc(`ADDR_CAUSE, 33'h0c);
    wr(`ADDR_CAUSE, 32'h3);
    wr(`ADDR_SCRATCH, 32'ha5);
    rdc(`ADDR_CAUSE, 33'h0f);
    rdc(12'h00c, 33'h100000000);
    pin_low <= 1'b1;
    repeat (5) @(posedge clock_in);
    pin_low <= 1'b0;
    repeat (20) @(posedge clock_in);
    check(core.core_run, 32'h1);
    pin_low <= 1'b1;
    repeat (30) @(posedge clock_in);
    check(core.core_run, 32'h0);
    pin_low <= 1'b0;
    wait_load(n);
    rdc(`ADDR_CAUSE, 33'h0f);
    rdc(`ADDR_SCRATCH, 33'ha5);
    kick(3);
    rdc(`ADDR_CAUSE, 33'h0b);
    cause.sleeping <= 1'b1;
    kick(3);
    check(core.pc_continue, 32'h1);
    cause.sleeping <= 1'b0;
    rdc(`ADDR_CAUSE, 33'h03);
    cause.sleeping <= 1'b1;
    cause.global_irq_enable <= 1'b1;
    kick(2);
    check({core.pc_continue, core.pc_target}, 32'h4);
    cause.sleeping <= 1'b0;
    rdc(`ADDR_CAUSE, 33'h07);
    wr(`ADDR_CAUSE, 32'h3);
    droop <= 1'b1;
    repeat (20) @(posedge clock_in);
    droop <= 1'b0;
    repeat (10) @(posedge clock_in);
    check(core.core_run, 32'h1);
    droop <= 1'b1;
    repeat (100) @(posedge clock_in);
    droop <= 1'b0;
    repeat (50) @(posedge clock_in);
    droop <= 1'b1;
    repeat (5) @(posedge clock_in);
    droop <= 1'b0;
    wait_load(n);
    check(n >= 200, 32'h1);
    rdc(`ADDR_CAUSE, 33'h0e);
    cfg.external_reset_pin_enable <= 1'b0;
    pin_low <= 1'b1;
    repeat (30) @(posedge clock_in);
    check({core.core_run, core.shared_io_pin}, 32'h2);
    pin_low <= 1'b0;
    repeat (20) @(posedge clock_in);
    check(core.shared_io_pin, 32'h1);
    rstn_in <= 1'b0;
    pin_low <= 1'b1;
    cfg <= {1'b1, 1'b1, 1'b1, 3'h3};
    @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (1500) @(posedge clock_in);
    check(core.core_run, 32'h0);
    pin_low <= 1'b0;
    wait_load(n);
    check(n < 20, 32'h1);
    rdc(`ADDR_SCRATCH, 33'h0);
    rdc(`ADDR_CAUSE, 33'h0c);
    end_of_test();
  end
endmodule
